// [verilog/tdc_channel_pll_trigger_config.sv]
// ahb-lite register bank for channel, pll and trigger configuration
//
// The implementer's own choice: register access over AHB-Lite.
`include "tdc_cfg_map.svh"

module tdc_channel_pll_trigger_config (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // configuration to the measurement core
  output tdc_cfg_pkg::cfg_t      cfg
);
  import tdc_cfg_pkg::*;

  reg_word_t regs_ff [`NUM_REGS];
  logic      wr_pend_ff;
  slot_t     wr_slot_ff;
  logic [31:0] hrdata_ff;
  logic      hreadyout_ff;
  logic      hresp_ff;

  logic      acc;
  logic      acc_hit;
  slot_t     acc_slot;
  reg_word_t nxt_rd;

  // only single word transfers are issued, so hsize is not decoded
  assign acc = hsel & hready & (htrans == `HTRANS_NONSEQ);

  always_comb begin
    acc_hit  = 1'b1;
    acc_slot = `SLOT_CH87;
    if (haddr[31:2] == `IDX_CH87) begin
      acc_slot = `SLOT_CH87;
    end else if (haddr[31:2] == `IDX_REFDLY) begin
      acc_slot = `SLOT_REFDLY;
    end else if (haddr[31:2] == `IDX_INIT) begin
      acc_slot = `SLOT_INIT;
    end else if (haddr[31:2] == `IDX_TWIN) begin
      acc_slot = `SLOT_TWIN;
    end else if (haddr[31:2] == `IDX_TLAT) begin
      acc_slot = `SLOT_TLAT;
    end else if (haddr[31:2] == `IDX_PLL) begin
      acc_slot = `SLOT_PLL;
    end else begin
      acc_hit = 1'b0;
    end
  end

  // write address phase is held until data arrives one cycle later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_slot_ff <= `SLOT_CH87;
    end else begin
      wr_pend_ff <= acc & hwrite & acc_hit;
      wr_slot_ff <= acc_slot;
    end
  end

  // storage; unmapped writes are dropped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < `NUM_REGS; i++) begin
        regs_ff[i] <= `REG_RESET;
      end
    end else if (wr_pend_ff) begin
      regs_ff[wr_slot_ff] <= hwdata[15:0];
    end
  end

  // read directly after a write to the same word sees the new data
  always_comb begin
    nxt_rd = `RD_UNMAPPED;
    if (acc_hit) begin
      if (wr_pend_ff && (wr_slot_ff == acc_slot)) begin
        nxt_rd = hwdata[15:0];
      end else begin
        nxt_rd = regs_ff[acc_slot];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrdata_ff <= {`RD_PAD, `RD_UNMAPPED};
    end else if (acc && !hwrite) begin
      hrdata_ff <= {`RD_PAD, nxt_rd};
    end
  end

  // zero wait states, always okay
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= `HRESP_OKAY;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= `HRESP_OKAY;
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;

  // field fan-out, wired straight from the stored words
  assign cfg.falling_edge_en_ch8 =
    regs_ff[`SLOT_CH87][`R5_FALL8];
  assign cfg.rising_edge_en_ch8 =
    regs_ff[`SLOT_CH87][`R5_RISE8];
  assign cfg.fine_delay_ch8 =
    regs_ff[`SLOT_CH87][`R5_ADJ8_MSB:`R5_ADJ8_LSB];
  assign cfg.falling_edge_en_ch7 =
    regs_ff[`SLOT_CH87][`R5_FALL7];
  assign cfg.rising_edge_en_ch7 =
    regs_ff[`SLOT_CH87][`R5_RISE7];
  assign cfg.fine_delay_ch7 =
    regs_ff[`SLOT_CH87][`R5_ADJ7_MSB:`R5_ADJ7_LSB];
  assign cfg.bus_clk_delay =
    regs_ff[`SLOT_REFDLY][`R6_BCD_MSB:`R6_BCD_LSB];
  assign cfg.fine_delay_ref_b =
    regs_ff[`SLOT_REFDLY][`R6_REFB_MSB:`R6_REFB_LSB];
  assign cfg.fine_delay_ref_a =
    regs_ff[`SLOT_REFDLY][`R6_REFA_MSB:`R6_REFA_LSB];
  // the core treats 0 as not yet initialised
  assign cfg.init_done =
    regs_ff[`SLOT_INIT][`R7_INIT];
  assign cfg.sync_range =
    regs_ff[`SLOT_INIT][`R7_RANGE_MSB:`R7_RANGE_LSB];
  assign cfg.hit_strobe_time =
    regs_ff[`SLOT_INIT][`R7_HIT_MSB:`R7_HIT_LSB];
  assign cfg.trig_win_width = regs_ff[`SLOT_TWIN];
  assign cfg.trig_win_latency = regs_ff[`SLOT_TLAT];
  assign cfg.diag_select_1 =
    regs_ff[`SLOT_PLL][`R10_DIAG1];
  assign cfg.pll_diag_en =
    regs_ff[`SLOT_PLL][`R10_TESTPLL];
  assign cfg.pll_loop_open =
    regs_ff[`SLOT_PLL][`R10_OPEN];
  assign cfg.pll_phase_invert =
    regs_ff[`SLOT_PLL][`R10_NEG];
  assign cfg.res_adjust_en =
    regs_ff[`SLOT_PLL][`R10_RADJ];
  assign cfg.ref_clk_div =
    regs_ff[`SLOT_PLL][`R10_REFDIV_MSB:`R10_REFDIV_LSB];
  assign cfg.hs_fb_div =
    regs_ff[`SLOT_PLL][`R10_HSDIV_MSB:`R10_HSDIV_LSB];

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_wr_addr(logic [29:0] idx);
    acc && hwrite && (haddr[31:2] == idx);
  endsequence

  sequence s_wr_data(slot_t s);
    wr_pend_ff && (wr_slot_ff == s);
  endsequence

  chk_ch8_edges: assert property (
    s_wr_data(`SLOT_CH87) |=>
      cfg.falling_edge_en_ch8 == $past(hwdata[15]) &&
      cfg.rising_edge_en_ch8 == $past(hwdata[14]) &&
      cfg.fine_delay_ch8 == $past(hwdata[13:8]))
    else $error("ch8 fields do not follow write");

  chk_ch7_edges: assert property (
    s_wr_addr(`IDX_CH87) ##1 1'b1 |=>
      cfg.falling_edge_en_ch7 == $past(hwdata[7]) &&
      cfg.rising_edge_en_ch7 == $past(hwdata[6]) &&
      cfg.fine_delay_ch7 == $past(hwdata[5:0]))
    else $error("ch7 fields do not follow write");

  chk_ref_delays: assert property (
    s_wr_data(`SLOT_REFDLY) |=>
      cfg.bus_clk_delay == $past(hwdata[15:12]) &&
      cfg.fine_delay_ref_b == $past(hwdata[11:6]) &&
      cfg.fine_delay_ref_a == $past(hwdata[5:0]))
    else $error("reference delay fields wrong");

  chk_init_flag: assert property (
    s_wr_addr(`IDX_INIT) ##1 1'b1 |=>
      cfg.init_done == $past(hwdata[15]))
    else $error("init flag does not follow write");

  chk_range_hit: assert property (
    s_wr_data(`SLOT_INIT) |=>
      cfg.sync_range == $past(hwdata[14:6]) &&
      cfg.hit_strobe_time == $past(hwdata[5:0]))
    else $error("range or hit time field wrong");

  chk_trig_window: assert property (
    s_wr_data(`SLOT_TWIN) |=>
      cfg.trig_win_width == $past(hwdata[15:0]) &&
      $stable(cfg.trig_win_latency))
    else $error("trigger window width wrong");

  chk_trig_latency: assert property (
    s_wr_addr(`IDX_TLAT) ##1 1'b1 |=>
      cfg.trig_win_latency == $past(hwdata[15:0]))
    else $error("trigger latency wrong");

  chk_pll_ctrl: assert property (
    s_wr_data(`SLOT_PLL) |=>
      cfg.diag_select_1 == $past(hwdata[15]) &&
      cfg.pll_diag_en == $past(hwdata[14]) &&
      cfg.pll_loop_open == $past(hwdata[13]) &&
      cfg.pll_phase_invert == $past(hwdata[12]))
    else $error("pll control bits wrong");

  chk_pll_divs: assert property (
    s_wr_data(`SLOT_PLL) |=>
      cfg.res_adjust_en == $past(hwdata[11]) &&
      cfg.ref_clk_div == $past(hwdata[10:8]) &&
      cfg.hs_fb_div == $past(hwdata[7:0]))
    else $error("pll divider fields wrong");

  chk_hold_value: assert property (
    !wr_pend_ff |=> $stable(cfg))
    else $error("config changed without a write");

  chk_read_back: assert property (
    acc && !hwrite && acc_hit && !wr_pend_ff |=>
      hrdata == {16'h0000, $past(regs_ff[acc_slot])} ##1
      hreadyout)
    else $error("read data differs from stored word");

  chk_unmapped_rd: assert property (
    acc && !hwrite && !acc_hit |=> hrdata == 32'h0000_0000 && !hresp)
    else $error("unmapped read not zero okay");

  // read address phase of one mapped word
  sequence s_rd_addr(logic [29:0] idx);
    acc && !hwrite && (haddr[31:2] == idx);
  endsequence

  // reset must be watched while it is high, so no disable here
  chk_reset_clear: assert property (
    @(posedge core_clk) disable iff (1'b0)
    rst |=> cfg == '0 && hrdata == 32'h0000_0000 &&
      hreadyout && !hresp)
    else $error("reset did not clear the bank");

  chk_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("wait state or error response seen");

  chk_rd_pad: assert property (
    hrdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  // forwarding: the read overlaps the data phase of the write
  chk_fwd_read: assert property (
    acc && !hwrite && acc_hit && wr_pend_ff &&
      (wr_slot_ff == acc_slot) |=>
      hrdata[15:0] == $past(hwdata[15:0]))
    else $error("read after write lost the new data");

  chk_unmapped_wr: assert property (
    acc && hwrite && !acc_hit ##1 1'b1 |=> $stable(cfg))
    else $error("unmapped write changed the bank");

  chk_rd_no_change: assert property (
    acc && !hwrite && !wr_pend_ff |=> $stable(cfg))
    else $error("read changed the bank");

  chk_hrdata_hold: assert property (
    !(acc && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");

  chk_wr_no_rdata: assert property (
    acc && hwrite |=> $stable(hrdata))
    else $error("write disturbed read data");

  // the core may sample init_done at any time, so it must not drop without a write to the init word
  chk_init_sticky: assert property (
    cfg.init_done && !(wr_pend_ff && wr_slot_ff == `SLOT_INIT) |=>
      cfg.init_done)
    else $error("init flag dropped without a write");

  // each word is private: writes elsewhere must leave it alone
  chk_keep_ch87: assert property (
    wr_pend_ff && wr_slot_ff != `SLOT_CH87 |=>
      $stable(regs_ff[`SLOT_CH87]))
    else $error("channel word changed by another write");

  chk_keep_refdly: assert property (
    wr_pend_ff && wr_slot_ff != `SLOT_REFDLY |=>
      $stable(regs_ff[`SLOT_REFDLY]))
    else $error("reference word changed by another write");

  chk_keep_init: assert property (
    wr_pend_ff && wr_slot_ff != `SLOT_INIT |=>
      $stable(regs_ff[`SLOT_INIT]))
    else $error("init word changed by another write");

  chk_keep_twin: assert property (
    wr_pend_ff && wr_slot_ff != `SLOT_TWIN |=>
      $stable(regs_ff[`SLOT_TWIN]))
    else $error("window word changed by another write");

  chk_keep_tlat: assert property (
    wr_pend_ff && wr_slot_ff != `SLOT_TLAT |=>
      $stable(regs_ff[`SLOT_TLAT]))
    else $error("latency word changed by another write");

  chk_keep_pll: assert property (
    wr_pend_ff && wr_slot_ff != `SLOT_PLL |=>
      $stable(regs_ff[`SLOT_PLL]))
    else $error("pll word changed by another write");

  // readback per word, with no write in flight
  chk_rd_ch87: assert property (
    s_rd_addr(`IDX_CH87) ##0 !wr_pend_ff |=>
      hrdata[15:0] == $past(regs_ff[`SLOT_CH87]))
    else $error("channel word read back wrong");

  chk_rd_refdly: assert property (
    s_rd_addr(`IDX_REFDLY) ##0 !wr_pend_ff |=>
      hrdata[15:0] == $past(regs_ff[`SLOT_REFDLY]))
    else $error("reference word read back wrong");

  chk_rd_init: assert property (
    s_rd_addr(`IDX_INIT) ##0 !wr_pend_ff |=>
      hrdata[15:0] == $past(regs_ff[`SLOT_INIT]))
    else $error("init word read back wrong");

  chk_rd_twin: assert property (
    s_rd_addr(`IDX_TWIN) ##0 !wr_pend_ff |=>
      hrdata[15:0] == $past(cfg.trig_win_width))
    else $error("window word read back wrong");

  chk_rd_tlat: assert property (
    s_rd_addr(`IDX_TLAT) ##0 !wr_pend_ff |=>
      hrdata[15:0] == $past(cfg.trig_win_latency))
    else $error("latency word read back wrong");

  chk_rd_pll: assert property (
    s_rd_addr(`IDX_PLL) ##0 !wr_pend_ff |=>
      hrdata[15:0] == $past(regs_ff[`SLOT_PLL]))
    else $error("pll word read back wrong");

endmodule

// [verilog/tdc_cfg_map.svh]
// register indices, field positions and reset values of the config bank
`ifndef TDC_CFG_MAP_SVH
`define TDC_CFG_MAP_SVH

// register indices; byte address is four times the index
`define IDX_CH87        30'h0000_0005
`define IDX_REFDLY      30'h0000_0006
`define IDX_INIT        30'h0000_0007
`define IDX_TWIN        30'h0000_0008
`define IDX_TLAT        30'h0000_0009
`define IDX_PLL         30'h0000_000a

// storage slots
`define NUM_REGS        6
`define SLOT_CH87       3'h0
`define SLOT_REFDLY     3'h1
`define SLOT_INIT       3'h2
`define SLOT_TWIN       3'h3
`define SLOT_TLAT       3'h4
`define SLOT_PLL        3'h5

`define REG_RESET       16'h0000
`define RD_UNMAPPED     16'h0000
`define RD_PAD          16'h0000

// ahb-lite encodings
`define HTRANS_NONSEQ   2'h2
`define HRESP_OKAY      1'h0

// channel 8 / 7 register
`define R5_FALL8        15
`define R5_RISE8        14
`define R5_ADJ8_MSB     13
`define R5_ADJ8_LSB     8
`define R5_FALL7        7
`define R5_RISE7        6
`define R5_ADJ7_MSB     5
`define R5_ADJ7_LSB     0

// bus clock delay / reference register
`define R6_BCD_MSB      15
`define R6_BCD_LSB      12
`define R6_REFB_MSB     11
`define R6_REFB_LSB     6
`define R6_REFA_MSB     5
`define R6_REFA_LSB     0

// init / range / hit time register
`define R7_INIT         15
`define R7_RANGE_MSB    14
`define R7_RANGE_LSB    6
`define R7_HIT_MSB      5
`define R7_HIT_LSB      0

// pll and diagnosis register
`define R10_DIAG1       15
`define R10_TESTPLL     14
`define R10_OPEN        13
`define R10_NEG         12
`define R10_RADJ        11
`define R10_REFDIV_MSB  10
`define R10_REFDIV_LSB  8
`define R10_HSDIV_MSB   7
`define R10_HSDIV_LSB   0

`endif

// [verilog/tdc_cfg_pkg.sv]
// types shared by the channel, pll and trigger config bank
package tdc_cfg_pkg;

  typedef struct packed {
    logic       falling_edge_en_ch8;
    logic       rising_edge_en_ch8;
    logic [5:0] fine_delay_ch8;
    logic       falling_edge_en_ch7;
    logic       rising_edge_en_ch7;
    logic [5:0] fine_delay_ch7;
    logic [3:0] bus_clk_delay;
    logic [5:0] fine_delay_ref_b;
    logic [5:0] fine_delay_ref_a;
    logic       init_done;
    logic [8:0] sync_range;
    logic [5:0] hit_strobe_time;
    logic [15:0] trig_win_width;
    logic [15:0] trig_win_latency;
    logic       diag_select_1;
    logic       pll_diag_en;
    logic       pll_loop_open;
    logic       pll_phase_invert;
    logic       res_adjust_en;
    logic [2:0] ref_clk_div;
    logic [7:0] hs_fb_div;
  } cfg_t;

  typedef logic [15:0] reg_word_t;
  typedef logic [2:0]  slot_t;

endpackage

// [verif/tb.sv]
// self-checking bench for the channel, pll and trigger config bank
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tdc_cfg_pkg::*;

  logic        core_clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  cfg_t        cfg;
  reg_word_t   shadow [0:15];
  logic [31:0] rnd_state;
  logic [31:0] rd;
  logic [31:0] corner [4];
  logic [29:0] odd_idx [6];
  int          err_total;
  int          samples_checked;

  // single slave: its own ready is the bus ready
  assign hready = hreadyout;

  tdc_channel_pll_trigger_config dut (
    .core_clk  (core_clk),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .cfg       (cfg)
  );

  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  function automatic logic [31:0] xorshift();
    rnd_state = rnd_state ^ (rnd_state << 13);
    rnd_state = rnd_state ^ (rnd_state >> 17);
    rnd_state = rnd_state ^ (rnd_state << 5);
    return rnd_state;
  endfunction

  function automatic cfg_t exp_cfg();
    cfg_t c;
    c.falling_edge_en_ch8 = shadow[5][15];
    c.rising_edge_en_ch8  = shadow[5][14];
    c.fine_delay_ch8      = shadow[5][13:8];
    c.falling_edge_en_ch7 = shadow[5][7];
    c.rising_edge_en_ch7  = shadow[5][6];
    c.fine_delay_ch7      = shadow[5][5:0];
    c.bus_clk_delay       = shadow[6][15:12];
    c.fine_delay_ref_b    = shadow[6][11:6];
    c.fine_delay_ref_a    = shadow[6][5:0];
    c.init_done           = shadow[7][15];
    c.sync_range          = shadow[7][14:6];
    c.hit_strobe_time     = shadow[7][5:0];
    c.trig_win_width      = shadow[8];
    c.trig_win_latency    = shadow[9];
    c.diag_select_1       = shadow[10][15];
    c.pll_diag_en         = shadow[10][14];
    c.pll_loop_open       = shadow[10][13];
    c.pll_phase_invert    = shadow[10][12];
    c.res_adjust_en       = shadow[10][11];
    c.ref_clk_div         = shadow[10][10:8];
    c.hs_fb_div           = shadow[10][7:0];
    return c;
  endfunction

  function automatic logic [31:0] exp_rd(input logic [29:0] idx);
    if (idx >= 30'h5 && idx <= 30'ha) begin
      return {16'h0, shadow[idx[3:0]]};
    end
    return 32'h0;
  endfunction

  task automatic check(input string what, input logic [95:0] exp,
                       input logic [95:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // outputs are steady at the falling edge; also proves values hold
  always @(negedge core_clk) begin
    if (rst === 1'b0) check("cfg", exp_cfg(), cfg);
  end

  task automatic edge_ready();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    check("hresp", 96'h0, {95'h0, hresp});
    if (hready !== 1'b1) begin
      err_total++;
      test_done();
    end
  endtask

  task automatic addr_phase(input logic wr, input logic [29:0] idx);
    hsel   <= 1'b1;
    haddr  <= {idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
  endtask

  task automatic xfer(input logic wr, input logic [29:0] idx,
                      input logic [31:0] wd);
    addr_phase(wr, idx);
    edge_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
    if (wr && exp_rd(idx) !== 32'h0 || wr && idx >= 30'h5 && idx <= 30'ha) begin
      shadow[idx[3:0]] = wd[15:0];
    end
  endtask

  task automatic reg_read(input logic [29:0] idx);
    xfer(1'b0, idx, 32'h0);
    check("hrdata", {64'h0, exp_rd(idx)}, {64'h0, rd});
  endtask

  // read address phase overlaps the write's data phase
  task automatic write_then_read(input logic [29:0] idx,
                                 input logic [31:0] wd);
    addr_phase(1'b1, idx);
    edge_ready();
    hwdata <= wd;
    hwrite <= 1'b0;
    edge_ready();
    htrans <= 2'h0;
    shadow[idx[3:0]] = wd[15:0];
    edge_ready();
    check("hrdata", {64'h0, exp_rd(idx)}, {64'h0, hrdata});
  endtask

  initial begin
    logic [29:0] idx;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rnd_state = 32'h132e;
    err_total = 0;
    samples_checked = 0;
    corner = '{32'hffff_ffff, 32'h0000_8000, 32'h5555_aaaa, 32'h0000_0000};
    odd_idx = '{30'h0, 30'h4, 30'hb, 30'hf, 30'h2000_0005, 30'h105};
    foreach (shadow[i]) shadow[i] = 16'h0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 5; i <= 10; i++) reg_read(30'(i));
    foreach (corner[k]) begin
      for (int i = 5; i <= 10; i++) begin
        xfer(1'b1, 30'(i), corner[k]);
        reg_read(30'(i));
      end
    end
    // unmapped places: write dropped, read zero
    foreach (odd_idx[k]) begin
      xfer(1'b1, odd_idx[k], xorshift());
      reg_read(odd_idx[k]);
    end
    repeat (300) begin
      idx = 30'(5 + xorshift() % 6);
      case (xorshift() % 3)
        0: xfer(1'b1, idx, xorshift());
        1: reg_read(idx);
        default: write_then_read(idx, xorshift());
      endcase
    end
    // reset in mid-run clears every register
    rst <= 1'b1;
    foreach (shadow[i]) shadow[i] = 16'h0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int i = 5; i <= 10; i++) reg_read(30'(i));
    test_done();
  end
endmodule
